// file: core/sfs_pkg.sv
// Purpose: Shared constants for the standby fail-safe supervisor.
// Assumes: A 10 MHz core clock and 8-bit rail readings.
// Notes: The register offset, the control and throttle timer reset values and the fail-safe cycle count live here.

// ====================================================================
// Constants
// ====================================================================
package sfs_pkg;
	// Register map and field positions.
	localparam logic [7:0] DYN_START_TEMP_CTRL1_ADDR = 8'h36;
	localparam int STANDBY_LOW_EN_BIT = 1;
	localparam logic [7:0] DYN_START_TEMP_CTRL1_RST = 8'h00;
	localparam int CORE_LOW_STATUS_BIT = 1;
	// Rail code that stands for the 0.75 V powered threshold.
	localparam logic [7:0] RAIL_ON_CODE = 8'h40;
	// Full-speed duty cycle, 100 percent.
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] DUTY_ZERO = 8'h00;
	// Fail-safe timeout of 4.6 s, derived into cycles of the 10 MHz clock.
	localparam int FAILSAFE_MS = 4600;
	localparam int CLK_KHZ = 10000;
	localparam int FAILSAFE_CYC = FAILSAFE_MS * CLK_KHZ;
	localparam int FAILSAFE_W = 26;
	localparam int THR_TIMER_W = 16;
	localparam logic [15:0] THR_TIMER_RST = 16'h0000;
	// Power-on supervisor states, Gray coded along the usual path.
	typedef enum logic [1:0] {
		SFS_WAIT_RAIL = 2'b00,
		SFS_COUNTING = 2'b01,
		SFS_FULL_SPEED = 2'b11,
		SFS_NORMAL = 2'b10
	} sfs_state_t;
endpackage

// file: core/sfs_sync2.sv
// Purpose: Two-flop synchroniser for a level from outside the clock domain.
// Assumes: The input is a slow level.
// Notes: Only the second flop is visible to the rest of the design.
`timescale 1ns/1ns

// ====================================================================
// Synchroniser
// ====================================================================
module sfs_sync2 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta_r;

	// Two stages; the first is read by the second only.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: core/sfs_countdown.sv
// Purpose: Loadable down-counter that flags expiry.
// Assumes: LOAD is at least one.
// Notes: Restarting while running reloads the count.
`timescale 1ns/1ns

// ====================================================================
// Countdown
// ====================================================================
module sfs_countdown #(
	parameter int W = 26,
	parameter logic [W-1:0] LOAD = '1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic cancel,
	output logic running_r,
	output logic expired_r
);
	logic [W-1:0] count_r;

	// Counts down from LOAD - 1 after start; expiry is a held level until restart or cancel.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_r <= '0;
			running_r <= 1'b0;
			expired_r <= 1'b0;
		end else if (cancel) begin
			running_r <= 1'b0;
			expired_r <= 1'b0;
		end else if (start) begin
			count_r <= LOAD - W'(1);
			running_r <= 1'b1;
			expired_r <= 1'b0;
		end else if (running_r) begin
			if (count_r == '0) begin
				running_r <= 1'b0;
				expired_r <= 1'b1;
			end else begin
				count_r <= count_r - W'(1);
			end
		end
	end
endmodule

// file: core/sfs_supervisor.sv
// Purpose: Standby and power-on fail-safe supervision of the fan monitor.
// Assumes: Rail readings, limits and SMBus address hits come from logic on clk.
// Notes: The thermal throttle pin is asynchronous and is synchronised here.
`timescale 1ns/1ns

module sfs_supervisor #(
	parameter int unsigned FAILSAFE_CYCLES = sfs_pkg::FAILSAFE_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] cpu_core_rail,
	input wire logic [7:0] cpu_core_rail_low_limit,
	input wire logic core_low_alert_enable,
	input wire logic status_clear,
	input wire logic smbus_addressed,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic thermal_throttle_pin_n,
	output logic [7:0] reg_rdata_r,
	output logic core_low_status_r,
	output logic smbus_alert_n_r,
	output logic throttle_monitor_en_r,
	output logic [15:0] throttle_timer_r,
	output logic start_temp_adjust_en_r,
	output logic shutdown_allowed_r,
	output logic fan_full_speed_r,
	output logic fan_stop_r,
	output logic load_defaults_r,
	output logic [7:0] fan_duty_override_r
);
	localparam logic [sfs_pkg::FAILSAFE_W-1:0] FS_LOAD = sfs_pkg::FAILSAFE_W'(FAILSAFE_CYCLES);

	logic [7:0] dyn_start_temp_control_1_r;
	logic standby_core_low_enable;
	logic standby_low;
	logic rail_powered;
	logic thermal_sync_n;
	logic fs_start;
	logic fs_cancel;
	logic fs_running;
	logic fs_expired;
	logic defaults_now;
	sfs_pkg::sfs_state_t state_r;
	sfs_pkg::sfs_state_t state_nxt;

	// ====================================================================
	// Input conditioning
	// ====================================================================

	// The throttle pin arrives from the board and is synchronised first.
	sfs_sync2 #(
		.RST_VAL(1'b1)
	) u_thermal_sync (
		.clk(clk),
		.rstn(rstn),
		.d(thermal_throttle_pin_n),
		.q(thermal_sync_n)
	);

	// Standby low condition and rail powered detection.
	assign standby_core_low_enable = dyn_start_temp_control_1_r[sfs_pkg::STANDBY_LOW_EN_BIT];
	assign standby_low = standby_core_low_enable && (cpu_core_rail < cpu_core_rail_low_limit);
	assign rail_powered = (cpu_core_rail >= sfs_pkg::RAIL_ON_CODE);

	// ====================================================================
	// Register file
	// ====================================================================

	// The control register is written by the host and returns to default on a defaults load.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dyn_start_temp_control_1_r <= sfs_pkg::DYN_START_TEMP_CTRL1_RST;
		end else if (defaults_now) begin
			dyn_start_temp_control_1_r <= sfs_pkg::DYN_START_TEMP_CTRL1_RST;
		end else if (reg_wr_en && reg_addr == sfs_pkg::DYN_START_TEMP_CTRL1_ADDR) begin
			dyn_start_temp_control_1_r <= reg_wdata;
		end
	end

	// Read data shows the control register or the live status bit.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_addr == sfs_pkg::DYN_START_TEMP_CTRL1_ADDR) begin
			reg_rdata_r <= dyn_start_temp_control_1_r;
		end else begin
			reg_rdata_r <= 8'h00;
			reg_rdata_r[sfs_pkg::CORE_LOW_STATUS_BIT] <= core_low_status_r;
		end
	end

	// ====================================================================
	// Standby behaviour
	// ====================================================================

	// Sticky status bit; a set in the clearing cycle wins.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_low_status_r <= 1'b0;
		end else if (standby_low) begin
			core_low_status_r <= 1'b1;
		end else if (status_clear) begin
			core_low_status_r <= 1'b0;
		end
	end

	// Alert is low while the status bit stands and alerting is enabled.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			smbus_alert_n_r <= 1'b1;
		end else begin
			smbus_alert_n_r <= !((core_low_status_r || standby_low) && core_low_alert_enable);
		end
	end

	// Monitoring, adjustment and shutdown gates follow the standby low condition.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			throttle_monitor_en_r <= 1'b1;
			start_temp_adjust_en_r <= 1'b1;
			shutdown_allowed_r <= 1'b1;
		end else begin
			throttle_monitor_en_r <= !standby_low;
			start_temp_adjust_en_r <= !standby_low;
			shutdown_allowed_r <= !standby_low;
		end
	end

	// Throttle timer counts asserted cycles and holds its count while monitoring is off.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			throttle_timer_r <= sfs_pkg::THR_TIMER_RST;
		end else if (throttle_monitor_en_r && !standby_low && !thermal_sync_n && throttle_timer_r != 16'hFFFF) begin
			throttle_timer_r <= throttle_timer_r + 16'h0001;
		end
	end

	// ====================================================================
	// Power-on fail-safe
	// ====================================================================

	// Fail-safe countdown on the internal clock.
	sfs_countdown #(
		.W(sfs_pkg::FAILSAFE_W),
		.LOAD(FS_LOAD)
	) u_failsafe (
		.clk(clk),
		.rstn(rstn),
		.start(fs_start),
		.cancel(fs_cancel),
		.running_r(fs_running),
		.expired_r(fs_expired)
	);

	// Power-on state machine.
	always_comb begin
		state_nxt = state_r;
		fs_start = 1'b0;
		fs_cancel = 1'b0;
		defaults_now = 1'b0;
		case (state_r)
			sfs_pkg::SFS_WAIT_RAIL: begin
				if (smbus_addressed) begin
					state_nxt = sfs_pkg::SFS_NORMAL;
					defaults_now = 1'b1;
				end else if (rail_powered) begin
					state_nxt = sfs_pkg::SFS_COUNTING;
					fs_start = 1'b1;
				end
			end
			sfs_pkg::SFS_COUNTING: begin
				if (smbus_addressed) begin
					state_nxt = sfs_pkg::SFS_NORMAL;
					fs_cancel = 1'b1;
					defaults_now = 1'b1;
				end else if (fs_expired) begin
					state_nxt = sfs_pkg::SFS_FULL_SPEED;
				end
			end
			sfs_pkg::SFS_FULL_SPEED: begin
				if (smbus_addressed) begin
					state_nxt = sfs_pkg::SFS_NORMAL;
					fs_cancel = 1'b1;
					defaults_now = 1'b1;
				end
			end
			sfs_pkg::SFS_NORMAL: begin
				state_nxt = sfs_pkg::SFS_NORMAL;
			end
			default: begin
				state_nxt = sfs_pkg::SFS_WAIT_RAIL;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= sfs_pkg::SFS_WAIT_RAIL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Fan forcing, fan stop and defaults pulses.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fan_full_speed_r <= 1'b0;
			fan_duty_override_r <= sfs_pkg::DUTY_ZERO;
			fan_stop_r <= 1'b0;
			load_defaults_r <= 1'b0;
		end else begin
			fan_full_speed_r <= (state_nxt == sfs_pkg::SFS_FULL_SPEED);
			fan_duty_override_r <= (state_nxt == sfs_pkg::SFS_FULL_SPEED) ? sfs_pkg::DUTY_FULL
				: sfs_pkg::DUTY_ZERO;
			fan_stop_r <= (state_r == sfs_pkg::SFS_FULL_SPEED) && smbus_addressed;
			load_defaults_r <= defaults_now;
		end
	end

	// ====================================================================
	// Assertions
	// ====================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_counting_entry;
		state_r == sfs_pkg::SFS_WAIT_RAIL && !smbus_addressed && rail_powered;
	endsequence

	sequence s_address_hit;
		state_r == sfs_pkg::SFS_FULL_SPEED && smbus_addressed;
	endsequence

	// Expiry seen while still counting, with no host rescue in the same cycle.
	sequence s_expiry_seen;
		state_r == sfs_pkg::SFS_COUNTING && fs_expired && !smbus_addressed;
	endsequence

	// Host rescue that arrives while still counting, before the fans are forced.
	sequence s_early_hit;
		state_r == sfs_pkg::SFS_COUNTING && smbus_addressed;
	endsequence

	a_status_sets: assert property (standby_low |=> core_low_status_r)
		else $error("Core low status not set.");
	a_alert_gated: assert property (!core_low_alert_enable |=> smbus_alert_n_r)
		else $error("Alert raised while disabled.");
	a_alert_fires: assert property (standby_low && core_low_alert_enable |=> !smbus_alert_n_r)
		else $error("Alert missing on core low.");
	a_timer_holds: assert property (standby_low [*2] |=> $stable(throttle_timer_r))
		else $error("Throttle timer moved in standby.");
	a_adjust_stops: assert property (standby_low |=> !start_temp_adjust_en_r && !throttle_monitor_en_r)
		else $error("Adjustment not stopped in standby.");
	a_no_shutdown: assert property (standby_low |=> !shutdown_allowed_r)
		else $error("Shutdown allowed in standby.");
	a_resume_all: assert property (!standby_low |=> shutdown_allowed_r && start_temp_adjust_en_r)
		else $error("Normal operation not resumed.");
	// The countdown is checked on the first edge after entry, so a rescue one cycle later cannot trip it.
	a_count_starts: assert property (s_counting_entry |=> state_r == sfs_pkg::SFS_COUNTING && fs_running)
		else $error("Fail-safe countdown did not start.");
	a_full_duty: assert property (fan_full_speed_r |-> fan_duty_override_r == sfs_pkg::DUTY_FULL)
		else $error("Full speed without full duty.");
	a_late_address: assert property (s_address_hit |=> fan_stop_r && load_defaults_r && !fan_full_speed_r)
		else $error("Late addressing did not stop fans.");
	a_early_address: assert property (state_r == sfs_pkg::SFS_COUNTING && smbus_addressed
		|=> state_r == sfs_pkg::SFS_NORMAL && !fan_full_speed_r [*3])
		else $error("Early addressing forced fans.");
	a_unpowered_wait: assert property (state_r == sfs_pkg::SFS_WAIT_RAIL && smbus_addressed
		|=> load_defaults_r && state_r == sfs_pkg::SFS_NORMAL)
		else $error("Defaults not loaded on first addressing.");
	a_rail_threshold: assert property (state_r == sfs_pkg::SFS_WAIT_RAIL && !smbus_addressed
		&& cpu_core_rail < sfs_pkg::RAIL_ON_CODE |=> state_r == sfs_pkg::SFS_WAIT_RAIL)
		else $error("Countdown started below rail threshold.");

	// Sticky status, alert release and resumed monitoring outside standby.
	a_status_sticky: assert property (core_low_status_r && !status_clear |=> core_low_status_r)
		else $error("Core low status dropped without a clear.");
	a_status_clears: assert property (status_clear && !standby_low |=> !core_low_status_r)
		else $error("Core low status not cleared.");
	a_alert_idle: assert property (!core_low_status_r && !standby_low |=> smbus_alert_n_r)
		else $error("Alert held with no low condition.");
	a_monitor_resumes: assert property (!standby_low |=> throttle_monitor_en_r)
		else $error("Throttle monitoring not resumed.");
	a_timer_resumes: assert property (!standby_low && throttle_monitor_en_r && !thermal_sync_n
		&& throttle_timer_r != 16'hFFFF |=> throttle_timer_r != $past(throttle_timer_r))
		else $error("Throttle timer stalled outside standby.");

	// Fan forcing only after a lapsed countdown, released by the host.
	a_full_holds: assert property (state_r == sfs_pkg::SFS_FULL_SPEED && !smbus_addressed
		|=> fan_full_speed_r && fan_duty_override_r == sfs_pkg::DUTY_FULL)
		else $error("Full speed dropped without addressing.");
	a_expiry_forces: assert property (s_expiry_seen |=> state_r == sfs_pkg::SFS_FULL_SPEED && fan_full_speed_r)
		else $error("Expiry did not force the fans.");
	a_no_early_force: assert property (state_r == sfs_pkg::SFS_COUNTING && !fs_expired |=> !fan_full_speed_r)
		else $error("Fans forced before expiry.");
	a_early_no_stop: assert property (s_early_hit |=> !fan_stop_r && load_defaults_r)
		else $error("Early addressing stopped fans or skipped defaults.");
	a_normal_calm: assert property (state_r == sfs_pkg::SFS_NORMAL |-> !fan_full_speed_r)
		else $error("Fans forced in normal operation.");
	a_defaults_reset_ctrl: assert property (load_defaults_r
		|-> dyn_start_temp_control_1_r == sfs_pkg::DYN_START_TEMP_CTRL1_RST)
		else $error("Control register not at default after defaults load.");
endmodule

// file: dv/sfs_host_model.sv
// Purpose: Behavioural SMBus host that addresses the supervisor and reaches its registers.
// Assumes: Every request changes just after a rising edge of clk and holds for one whole cycle.
// Notes: Released write data shows the inverse of its last value, so stale data never looks valid.
`timescale 1ns/1ns

// ====================================================================
// Host model
// ====================================================================
module sfs_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata_r,
	output logic smbus_addressed,
	output logic status_clear,
	output logic reg_wr_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// All strobes idle from time zero.
	initial begin
		smbus_addressed = 1'b0;
		status_clear = 1'b0;
		reg_wr_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h5A;
	end

	// One valid transaction that addresses the device.
	task automatic address_dev();
		@(posedge clk);
		#1 smbus_addressed = 1'b1;
		@(posedge clk);
		#1 smbus_addressed = 1'b0;
	endtask

	// Single register write; the strobe stands for exactly one edge.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr_en = 1'b0;
		reg_wdata = ~d;
	endtask

	// Register read; data is taken once the registered answer has settled.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		@(posedge clk);
		@(posedge clk);
		#1 d = reg_rdata_r;
	endtask

	// Status read that clears the sticky low flag.
	task automatic clear_status();
		@(posedge clk);
		#1 status_clear = 1'b1;
		@(posedge clk);
		#1 status_clear = 1'b0;
	endtask
endmodule

// file: dv/standby_failsafe_supervisor_bench.sv
// Purpose: Self-checking bench for the standby and power-on fail-safe supervisor.
// Assumes: A shortened fail-safe count so the whole run stays short.
// Notes: Random rail, limit and control values come from a fixed-seed shift register.
`timescale 1ns/1ns

// ====================================================================
// Bench
// ====================================================================
module standby_failsafe_supervisor_bench;
	localparam int FS = 20;
	logic clk, rstn, core_low_alert_enable, thermal_throttle_pin_n;
	logic [7:0] cpu_core_rail, cpu_core_rail_low_limit, reg_rdata_r, reg_addr, reg_wdata;
	logic status_clear, smbus_addressed, reg_wr_en, core_low_status_r, smbus_alert_n_r;
	logic throttle_monitor_en_r, start_temp_adjust_en_r, shutdown_allowed_r;
	logic fan_full_speed_r, fan_stop_r, load_defaults_r;
	logic [15:0] throttle_timer_r, held;
	logic [7:0] fan_duty_override_r, rd, ctrl, lim, rail, lfsr;
	logic low, en;
	int bad_count, total_checks, n;

	sfs_supervisor #(.FAILSAFE_CYCLES(FS)) DUT (.clk(clk), .rstn(rstn), .cpu_core_rail(cpu_core_rail),
		.cpu_core_rail_low_limit(cpu_core_rail_low_limit), .core_low_alert_enable(core_low_alert_enable),
		.status_clear(status_clear), .smbus_addressed(smbus_addressed), .reg_wr_en(reg_wr_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .thermal_throttle_pin_n(thermal_throttle_pin_n),
		.reg_rdata_r(reg_rdata_r), .core_low_status_r(core_low_status_r), .smbus_alert_n_r(smbus_alert_n_r),
		.throttle_monitor_en_r(throttle_monitor_en_r), .throttle_timer_r(throttle_timer_r),
		.start_temp_adjust_en_r(start_temp_adjust_en_r), .shutdown_allowed_r(shutdown_allowed_r),
		.fan_full_speed_r(fan_full_speed_r), .fan_stop_r(fan_stop_r), .load_defaults_r(load_defaults_r),
		.fan_duty_override_r(fan_duty_override_r));

	sfs_host_model host (.clk(clk), .reg_rdata_r(reg_rdata_r), .smbus_addressed(smbus_addressed),
		.status_clear(status_clear), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// The 100 ns clock.
	initial clk = 1'b0;
	always #50 clk = ~clk;

	// Next value of the fixed-seed shift register.
	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// Expected standby low condition.
	function automatic logic exp_low(input logic [7:0] c, input logic [7:0] r, input logic [7:0] l);
		return c[1] && (r < l);
	endfunction

	// Compares a seen value with the expected one and counts both.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t ns: %s", $time, msg);
		end
	endtask

	// Lets k edges pass and steps just past the last one.
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Full reset with the rail already at its power-up level.
	task automatic power_on(input logic [7:0] r);
		rstn = 1'b0;
		cpu_core_rail = r;
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		final_report();
	end

	// Main sequence.
	initial begin
		bad_count = 0;
		total_checks = 0;
		lfsr = 8'h24;
		cpu_core_rail_low_limit = 8'h20;
		core_low_alert_enable = 1'b1;
		thermal_throttle_pin_n = 1'b1;
		power_on(8'h3F);
		check(smbus_alert_n_r, 1, "alert after reset");
		check(throttle_monitor_en_r & start_temp_adjust_en_r & shutdown_allowed_r, 1, "enables after reset");
		tick(FS + 10);
		check(fan_full_speed_r, 0, "countdown ran below rail threshold");
		host.address_dev();
		for (n = 0; n < 4 && load_defaults_r !== 1'b1; n++) tick(1);
		check(load_defaults_r, 1, "no defaults load on unpowered rail");
		cpu_core_rail = 8'h80;
		tick(FS + 10);
		check(fan_full_speed_r, 0, "countdown after normal entry");
		power_on(8'h40);
		tick(5);
		host.address_dev();
		tick(FS + 10);
		check({fan_full_speed_r, fan_duty_override_r}, 0, "fans forced after early addressing");
		power_on(8'h80);
		for (n = 0; n < FS + 20 && fan_full_speed_r !== 1'b1; n++) tick(1);
		check(n >= FS && n <= FS + 6, 1, "fail-safe expiry time");
		check(fan_duty_override_r, 8'hFF, "full speed duty");
		host.write_reg(8'h36, 8'h02);
		host.address_dev();
		for (n = 0; n < 4 && fan_stop_r !== 1'b1; n++) tick(1);
		check({fan_stop_r, load_defaults_r}, 2'b11, "stop and defaults after late addressing");
		tick(1);
		check({fan_full_speed_r, fan_stop_r, fan_duty_override_r}, 0, "fans still forced");
		host.read_reg(8'h36, rd);
		check(rd, 8'h00, "control register kept after defaults load");
		power_on(8'hFF);
		host.address_dev();
		thermal_throttle_pin_n = 1'b0;
		host.write_reg(8'h37, 8'hFF);
		host.read_reg(8'h36, rd);
		check(rd, 8'h00, "write to unmapped address landed");
		for (int i = 0; i < 40; i++) begin
			ctrl = lfsr;
			lim = lfsr_next(ctrl);
			rail = lfsr_next(lim);
			lfsr = lfsr_next(rail);
			en = lfsr[0];
			if (i == 0) begin
				ctrl = 8'h02;
				lim = 8'h80;
				rail = 8'h7F;
			end
			if (i == 1) rail = lim;
			host.write_reg(8'h36, ctrl);
			host.read_reg(8'h36, rd);
			check(rd, ctrl, "control register readback");
			low = exp_low(ctrl, rail, lim);
			core_low_alert_enable = en;
			cpu_core_rail_low_limit = lim;
			cpu_core_rail = rail;
			tick(2);
			held = throttle_timer_r;
			check(core_low_status_r, low, "status bit");
			check(smbus_alert_n_r, !(low && en), "alert level");
			check(throttle_monitor_en_r, !low, "throttle monitor enable");
			check(start_temp_adjust_en_r, !low, "start temperature adjust enable");
			check(shutdown_allowed_r, !low, "shutdown permission");
			if (low) begin
				host.clear_status();
				tick(1);
				check(core_low_status_r, 1, "status cleared during standby");
				check(throttle_timer_r, held, "throttle timer moved in standby");
			end
			host.read_reg(8'h37, rd);
			check(rd, {6'h00, low, 1'h0}, "status bit readback");
			cpu_core_rail = 8'hFF;
			tick(3);
			check(throttle_monitor_en_r & start_temp_adjust_en_r & shutdown_allowed_r, 1, "resume");
			if (low) check(throttle_timer_r != held, 1, "throttle timer frozen after recovery");
			host.clear_status();
			tick(2);
			check({core_low_status_r, smbus_alert_n_r}, 2'b01, "status or alert after clear");
		end
		final_report();
	end
endmodule
